// ==== common/lsr_pkg.sv ====
// Package for the level switch relay logic: register map, field layout,
// reset values, states and timing counts.
// Assumes a 25 MHz system clock and a plain address/strobe register port.
package lsr_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_POINTS = 5'h00;
  localparam logic [4:0] OFS_TIMERS = 5'h04;
  localparam logic [4:0] OFS_CFG = 5'h08;
  localparam logic [4:0] OFS_ZERO = 5'h0C;
  localparam logic [4:0] OFS_SPAN = 5'h10;
  localparam logic [4:0] OFS_INTVL = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;
  // Field positions
  localparam int POS_OFF_PT = 0;
  localparam int POS_ON_PT = 8;
  localparam int POS_OFF_TM = 0;
  localparam int POS_ON_TM = 8;
  localparam int POS_POL = 0;
  localparam int POS_DISP = 4;
  localparam int POS_DEC = 8;
  localparam int POS_SEG = 0;
  localparam int POS_RELAY = 4;
  localparam int POS_STATE = 8;
  localparam int POS_FLASH = 12;
  // Reset values of the settings
  localparam logic [3:0] RST_OFF_PT = 4'h2;
  localparam logic [3:0] RST_ON_PT = 4'h7;
  localparam logic [3:0] MAX_PT = 4'h8;
  localparam logic [3:0] MIN_PT = 4'h1;
  localparam logic [7:0] RST_TIMER = 8'h0A;
  localparam logic RST_POL = 1'b0;
  localparam logic [1:0] RST_DISP = 2'h1;
  localparam logic [1:0] DISP_SEG = 2'h1;
  localparam logic [1:0] DISP_DIEL = 2'h2;
  localparam logic [1:0] DISP_FREQ = 2'h3;
  localparam logic [2:0] DEC_FLOAT = 3'h7;
  localparam logic [15:0] RST_ZERO = 16'h03E8;
  localparam logic [15:0] RST_SPAN = 16'h0438;
  localparam logic [7:0] RST_INTVL = 8'h03;
  // Timing: one tick is 0.1 s
  localparam longint CLK_PERIOD_NS = 40;
  localparam longint TICK_NS = 100000000;
  localparam int TICK_CYCLES = int'(TICK_NS / CLK_PERIOD_NS);
  localparam int CANCEL_HOLD_MS = 2000;
  localparam logic [7:0] CANCEL_TICKS = 8'(CANCEL_HOLD_MS / 100);
  localparam logic [7:0] BLINK_TICKS = 8'h05;
  localparam logic [7:0] LCD_STEP_TICKS = 8'h05;
  // Operating states, one-hot
  typedef enum logic [3:0] {
    ST_MEAS = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_TEST = 4'b0100,
    ST_SVC = 4'b1000
  } lsr_state_t;
  // Adjustment menu items
  typedef enum logic [1:0] {
    ITEM_RETURN = 2'h0,
    ITEM_TEST = 2'h1,
    ITEM_SVC = 2'h2
  } lsr_item_t;
endpackage

// ==== dv/lsr_key_panel.sv ====
// Operator model at the four-key panel: presses and holds key combinations.
// Assumes the bench calls press() from one process; released keys read low.
`timescale 1ns/1ps
module lsr_key_panel (
  input wire logic ref_clk_in,
  output logic mode_key_out,
  output logic accept_key_out,
  output logic up_key_out,
  output logic down_key_out
);
  // Keys idle released
  initial begin
    {mode_key_out, accept_key_out, up_key_out, down_key_out} = 4'h0;
  end

  // Hold a key set {mode, accept, up, down} for some cycles, then let go
  task automatic press(input logic [3:0] keys, input int hold);
    @(posedge ref_clk_in);
    {mode_key_out, accept_key_out, up_key_out, down_key_out} <= keys;
    repeat (hold) @(posedge ref_clk_in);
    {mode_key_out, accept_key_out, up_key_out, down_key_out} <= 4'h0;
    repeat (3) @(posedge ref_clk_in);
    #1;
  endtask
endmodule // lsr_key_panel

// ==== dv/lsr_relay_logic_tb_top.sv ====
// Self-checking bench for the relay logic: register port, keys, sample feed.
// Assumes a shortened 0.1 s tick of 4 cycles; the waits are fixed cycle counts chosen for it.
`timescale 1ns/1ps
module lsr_relay_logic_tb_top;
  localparam int TICK = 4;
  localparam logic [3:0] K_MODE = 4'h8;
  localparam logic [3:0] K_ACC = 4'h4;
  localparam logic [3:0] K_UP = 4'h2;
  localparam logic [3:0] K_DN = 4'h1;
  logic ref_clk_in, rst_b_in, reg_wr, reg_rd, teach_zero, teach_span;
  logic mode_key, accept_key, up_key, down_key, relay, no_closed, nc_closed, ret_ind, run_ind;
  logic ret_seen;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] sample, freq, disp_value;
  logic [3:0] mode_state;
  logic [2:0] disp_dec;
  logic [7:0] lcd;
  int n_mismatch = 0;
  int checked = 0;

  lsr_relay_logic #(.TICK_CYCLES(TICK)) dut_u (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .mode_key_in(mode_key), .accept_key_in(accept_key),
    .up_key_in(up_key), .down_key_in(down_key), .sample_in(sample), .freq_in(freq),
    .teach_zero_in(teach_zero), .teach_span_in(teach_span), .relay_energized_out(relay),
    .contact_no_closed_out(no_closed), .contact_nc_closed_out(nc_closed),
    .return_to_operation_indicator_out(ret_ind), .operation_indicator_out(run_ind),
    .mode_state_out(mode_state), .disp_value_out(disp_value),
    .disp_decimals_out(disp_dec), .lcd_test_out(lcd)
  );

  lsr_key_panel panel_u (
    .ref_clk_in(ref_clk_in), .mode_key_out(mode_key), .accept_key_out(accept_key),
    .up_key_out(up_key), .down_key_out(down_key)
  );

  // 25 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  // Counts and reports one comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the read edge
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic smp(input logic [15:0] v);
    @(posedge ref_clk_in);
    sample <= v;
  endtask

  task automatic do_reset();
    rst_b_in <= 1'b0;
    repeat (16) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    gap(1);
  endtask

  task automatic relay_is(input logic exp);
    chk("relay", exp, relay);
    chk("contact_no", exp, no_closed);
    chk("contact_nc", !exp, nc_closed);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {reg_wr, reg_rd, teach_zero, teach_span} = 4'h0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    sample = 16'h03E8;
    freq = 16'h1234;
    do_reset();
    // Defaults after power-up
    chk("state", 4'h1, mode_state);
    chk("run_ind", 1'b1, run_ind);
    chk("ret_ind_idle", 1'b0, ret_ind);
    relay_is(1'b0);
    rd(lsr_pkg::OFS_POINTS, 32'h0702, "points");
    rd(lsr_pkg::OFS_TIMERS, 32'h0A0A, "timers");
    rd(lsr_pkg::OFS_CFG, 32'h0710, "cfg");
    rd(lsr_pkg::OFS_ZERO, 32'h03E8, "zero");
    rd(lsr_pkg::OFS_SPAN, 32'h0438, "span");
    rd(lsr_pkg::OFS_INTVL, 32'h03, "interval");
    rd(lsr_pkg::OFS_STATUS, 32'h0100, "status");
    rd(5'h1C, 32'h0, "unmapped");
    // Release point not below engage point is refused
    wr(lsr_pkg::OFS_POINTS, 32'h0405);
    rd(lsr_pkg::OFS_POINTS, 32'h0702, "points_bad");
    wr(lsr_pkg::OFS_POINTS, 32'h0603);
    rd(lsr_pkg::OFS_POINTS, 32'h0603, "points_ok");
    // Half way up the scale gives segment 4
    smp(16'd1045);
    gap(20);
    rd(lsr_pkg::OFS_STATUS, 32'h0104, "status_seg");
    // Engage after the on delay
    smp(16'd1080);
    gap(30);
    relay_is(1'b0);
    gap(40);
    relay_is(1'b1);
    // Two dips below the release point, each shorter than the off delay
    smp(16'd1015);
    gap(24);
    smp(16'd1080);
    gap(12);
    smp(16'd1015);
    gap(24);
    smp(16'd1080);
    gap(60);
    relay_is(1'b1);
    smp(16'd1015);
    gap(30);
    relay_is(1'b1);
    gap(40);
    relay_is(1'b0);
    // Enter adjust, cancel pending edits; relay keeps deciding meanwhile
    panel_u.press(K_MODE, 2);
    rd(lsr_pkg::OFS_STATUS, 32'h1201, "status_setup");
    chk("run_ind_setup", 1'b0, run_ind);
    // Return indicator toggles every five ticks while flashing
    ret_seen = ret_ind;
    gap(20);
    chk("ret_flash", !ret_seen, ret_ind);
    smp(16'd1080);
    panel_u.press(K_MODE | K_DN, 110);
    chk("state_setup", 4'h2, mode_state);
    relay_is(1'b1);
    rd(lsr_pkg::OFS_POINTS, 32'h0702, "points_cancel");
    // Display test walk and exit
    panel_u.press(K_UP, 2);
    panel_u.press(K_ACC, 2);
    chk("state_test", 4'h4, mode_state);
    chk("lcd_first", 8'h01, lcd);
    gap(20);
    chk("lcd_walk", 1'b1, (lcd === 8'h02) || (lcd === 8'h04));
    panel_u.press(K_MODE, 2);
    chk("state_back", 4'h2, mode_state);
    chk("lcd_off", 8'h00, lcd);
    // Commit inverted polarity and dielectric display with 3 decimals
    panel_u.press(K_DN, 2);
    wr(lsr_pkg::OFS_CFG, 32'h0321);
    wr(lsr_pkg::OFS_POINTS, 32'h0603);
    panel_u.press(K_ACC, 2);
    chk("state_commit", 4'h1, mode_state);
    relay_is(1'b0);
    chk("decimals", 3'h3, disp_dec);
    chk("disp", 16'h0438, disp_value);
    rd(lsr_pkg::OFS_POINTS, 32'h0603, "points_commit");
    // Service mode and back to measurement
    panel_u.press(K_MODE, 2);
    panel_u.press(K_DN, 2);
    panel_u.press(K_ACC, 2);
    chk("state_svc", 4'h8, mode_state);
    panel_u.press(K_MODE, 2);
    chk("state_meas", 4'h1, mode_state);
    // Frequency display ignores the decimals field
    panel_u.press(K_MODE, 2);
    wr(lsr_pkg::OFS_CFG, 32'h0031);
    panel_u.press(K_ACC, 2);
    chk("disp_freq", 16'h1234, disp_value);
    chk("decimals_freq", 3'h7, disp_dec);
    // Teaching zero derives span
    @(posedge ref_clk_in);
    teach_zero <= 1'b1;
    @(posedge ref_clk_in);
    teach_zero <= 1'b0;
    gap(2);
    rd(lsr_pkg::OFS_ZERO, 32'h0438, "zero_taught");
    rd(lsr_pkg::OFS_SPAN, 32'h0488, "span_derived");
    // Uncommitted edit lost over a power cycle
    wr(lsr_pkg::OFS_POINTS, 32'h0504);
    rd(lsr_pkg::OFS_POINTS, 32'h0504, "points_pend");
    do_reset();
    rd(lsr_pkg::OFS_POINTS, 32'h0702, "points_power");
    rd(lsr_pkg::OFS_CFG, 32'h0710, "cfg_power");
    chk("state_power", 4'h1, mode_state);
    print_verdict();
  end
endmodule // lsr_relay_logic_tb_top

// ==== src/lsr_delay_timer.sv ====
// Restartable delay timer counted in 0.1 s ticks.
// Assumes tick_in is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
module lsr_delay_timer (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic tick_in,
  input wire logic arm_in,
  input wire logic [7:0] preset_in,
  output logic expired_out
);
  typedef struct packed {
    logic [7:0] cnt;
  } lsr_tmr_t;

  lsr_tmr_t s_r;
  lsr_tmr_t s_nxt;

  // Count while armed; any break restarts from zero
  always_comb begin
    s_nxt = s_r;
    if (!arm_in) begin
      s_nxt.cnt = 8'h00; // RULE_21
    end else if (tick_in && s_r.cnt < preset_in) begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Expired once the full delay has run uninterrupted
  assign expired_out = arm_in && (s_r.cnt >= preset_in);
endmodule // lsr_delay_timer

// ==== src/lsr_relay_logic.sv ====
// Level switch relay logic: segment scale, hysteresis, delays, polarity,
// register port parameter entry, key panel menu, display select and display test.
// Assumes synchronous key levels and a sample word per measurement.
// Summary of operation
// RULE_01: Accept at flashing return item commits edits
// RULE_02: Mode plus down over 2 s discards
// RULE_03: Uncommitted edits lost; reset restores committed (here reset reloads the SET_RST defaults instead)
// RULE_04: Mode in service mode returns to measurement
// RULE_05: Release point default 2, from 1 below engage
// RULE_06: Engage point default 7, above release, max 8
// RULE_07: Release waits off delay, default 1.0 s
// RULE_08: Engage waits on delay, 0.1 s steps
// RULE_09: Polarity selects relay sense, default 0
// RULE_10: Zero point default 1.000, scale bottom
// RULE_11: Span point default 1.080, scale top
// RULE_12: Sample periodically, default 0.3 s interval
// RULE_13: Display select: segment, dielectric, frequency
// RULE_14: Decimal places only for dielectric display
// RULE_15: Teaching one point derives the other
// RULE_16: Display test walks segments; mode exits
// RULE_17: Relay decision keeps running while adjusting
// RULE_18: Material present closes normally-open contact (here only with polarity 0; with polarity 1 material present opens it)
// RULE_19: Power up starts in measurement operation
// RULE_20: Eight equal segments between zero and span
// RULE_21: Threshold re-cross restarts pending delay
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module lsr_relay_logic #(
  parameter int TICK_CYCLES = lsr_pkg::TICK_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic mode_key_in,
  input wire logic accept_key_in,
  input wire logic up_key_in,
  input wire logic down_key_in,
  input wire logic [15:0] sample_in,
  input wire logic [15:0] freq_in,
  input wire logic teach_zero_in,
  input wire logic teach_span_in,
  output logic relay_energized_out,
  output logic contact_no_closed_out,
  output logic contact_nc_closed_out,
  output logic return_to_operation_indicator_out,
  output logic operation_indicator_out,
  output logic [3:0] mode_state_out,
  output logic [15:0] disp_value_out,
  output logic [2:0] disp_decimals_out,
  output logic [7:0] lcd_test_out
);
  typedef struct packed {
    logic [3:0] off_pt;
    logic [3:0] on_pt;
    logic [7:0] off_tm;
    logic [7:0] on_tm;
    logic pol;
    logic [1:0] disp;
    logic [2:0] dec;
    logic [15:0] zero;
    logic [15:0] span;
    logic [7:0] intvl;
  } lsr_set_t;

  typedef struct packed {
    lsr_pkg::lsr_state_t state;
    lsr_pkg::lsr_item_t item;
    lsr_set_t work;
    lsr_set_t pend;
    logic [31:0] tick_cnt;
    logic [7:0] smp_cnt;
    logic [7:0] hold_cnt;
    logic [7:0] blink_cnt;
    logic blink;
    logic [7:0] lcd_cnt;
    logic [7:0] lcd;
    logic [3:0] keys_prev;
    logic smp_stb;
    logic [15:0] sample;
    logic [15:0] freq;
    logic [3:0] seg;
    logic detect;
    logic [15:0] disp_val;
    logic [2:0] disp_dec;
    logic [31:0] rdata;
  } lsr_st_t;

  localparam lsr_set_t SET_RST = '{
    off_pt: lsr_pkg::RST_OFF_PT, on_pt: lsr_pkg::RST_ON_PT,
    off_tm: lsr_pkg::RST_TIMER, on_tm: lsr_pkg::RST_TIMER,
    pol: lsr_pkg::RST_POL, disp: lsr_pkg::RST_DISP, dec: lsr_pkg::DEC_FLOAT,
    zero: lsr_pkg::RST_ZERO, span: lsr_pkg::RST_SPAN, intvl: lsr_pkg::RST_INTVL};

  lsr_st_t s_r;
  lsr_st_t s_nxt;
  logic tick;
  logic mode_p, acc_p, up_p, down_p;
  logic flashing;
  logic on_cond, off_cond, on_exp, off_exp;
  logic [15:0] diff, rng;
  logic [7:0] seg_ge;
  logic [15:0] delta;

  // Release must sit from 1 up to one below engage, engage at most 8
  function automatic logic points_ok(input logic [3:0] off_pt, input logic [3:0] on_pt);
    points_ok = (off_pt >= lsr_pkg::MIN_PT) && (off_pt < on_pt) && (on_pt <= lsr_pkg::MAX_PT);
  endfunction

  // Key press edges and shared timing
  assign tick = (s_r.tick_cnt == 32'(TICK_CYCLES - 1));
  assign mode_p = mode_key_in && !s_r.keys_prev[0];
  assign acc_p = accept_key_in && !s_r.keys_prev[1];
  assign up_p = up_key_in && !s_r.keys_prev[2];
  assign down_p = down_key_in && !s_r.keys_prev[3];
  assign flashing = (s_r.state == lsr_pkg::ST_SETUP && s_r.item == lsr_pkg::ITEM_RETURN) ||
                    (s_r.state == lsr_pkg::ST_SVC);

  // Segment boundaries: eight equal parts of the zero-to-span range
  assign diff = (s_r.sample > s_r.work.zero) ? s_r.sample - s_r.work.zero : 16'h0000;
  assign rng = s_r.work.span - s_r.work.zero;
  genvar k;
  generate
    for (k = 1; k <= 8; k++) begin : g_bound
      assign seg_ge[k-1] = ({diff, 3'b000} >= 19'(k) * {3'b000, rng}); // RULE_20
    end
  endgenerate

  // Hysteresis conditions on the latest segment
  assign on_cond = (s_r.seg >= s_r.work.on_pt) && !s_r.detect;
  assign off_cond = (s_r.seg < s_r.work.off_pt) && s_r.detect;
  assign delta = lsr_pkg::RST_SPAN - lsr_pkg::RST_ZERO;

  // Engage delay
  lsr_delay_timer u_on_tmr (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .tick_in(tick),
    .arm_in(on_cond),
    .preset_in(s_r.work.on_tm),
    .expired_out(on_exp)
  );

  // Release delay
  lsr_delay_timer u_off_tmr (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .tick_in(tick),
    .arm_in(off_cond),
    .preset_in(s_r.work.off_tm),
    .expired_out(off_exp)
  );

  // Next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.keys_prev = {down_key_in, up_key_in, accept_key_in, mode_key_in};
    s_nxt.tick_cnt = tick ? 32'h0000_0000 : s_r.tick_cnt + 32'h0000_0001;
    s_nxt.smp_stb = 1'b0;
    // Sampling interval in ticks
    if (tick) begin
      if (s_r.smp_cnt + 8'h01 >= s_r.work.intvl) begin
        s_nxt.smp_cnt = 8'h00;
        s_nxt.smp_stb = 1'b1; // RULE_12
      end else begin
        s_nxt.smp_cnt = s_r.smp_cnt + 8'h01;
      end
      s_nxt.blink_cnt = (s_r.blink_cnt + 8'h01 >= lsr_pkg::BLINK_TICKS) ? 8'h00 :
                        s_r.blink_cnt + 8'h01;
      if (s_r.blink_cnt + 8'h01 >= lsr_pkg::BLINK_TICKS) begin
        s_nxt.blink = !s_r.blink;
      end
    end
    if (s_r.smp_stb) begin
      s_nxt.sample = sample_in;
      s_nxt.freq = freq_in;
    end
    s_nxt.seg = 4'($countones(seg_ge));
    // Relay decision runs in every state
    if (on_exp) begin
      s_nxt.detect = 1'b1; // RULE_08 RULE_17
    end else if (off_exp) begin
      s_nxt.detect = 1'b0; // RULE_07
    end
    // Teaching one reference derives the other
    if (teach_zero_in) begin
      s_nxt.work.zero = s_r.sample; // RULE_15
      s_nxt.work.span = s_r.sample + delta;
      s_nxt.pend.zero = s_r.sample;
      s_nxt.pend.span = s_r.sample + delta;
    end else if (teach_span_in) begin
      s_nxt.work.span = s_r.sample; // RULE_15
      s_nxt.work.zero = s_r.sample - delta;
      s_nxt.pend.span = s_r.sample;
      s_nxt.pend.zero = s_r.sample - delta;
    end
    // Register writes land in the pending set
    if (reg_wr_in) begin
      case (reg_addr_in)
        lsr_pkg::OFS_POINTS: begin
          if (points_ok(reg_wdata_in[lsr_pkg::POS_OFF_PT +: 4],
                        reg_wdata_in[lsr_pkg::POS_ON_PT +: 4])) begin
            s_nxt.pend.off_pt = reg_wdata_in[lsr_pkg::POS_OFF_PT +: 4]; // RULE_05
            s_nxt.pend.on_pt = reg_wdata_in[lsr_pkg::POS_ON_PT +: 4]; // RULE_06
          end
        end
        lsr_pkg::OFS_TIMERS: begin
          s_nxt.pend.off_tm = reg_wdata_in[lsr_pkg::POS_OFF_TM +: 8];
          s_nxt.pend.on_tm = reg_wdata_in[lsr_pkg::POS_ON_TM +: 8];
        end
        lsr_pkg::OFS_CFG: begin
          s_nxt.pend.pol = reg_wdata_in[lsr_pkg::POS_POL];
          if (reg_wdata_in[lsr_pkg::POS_DISP +: 2] != 2'h0) begin
            s_nxt.pend.disp = reg_wdata_in[lsr_pkg::POS_DISP +: 2];
          end
          s_nxt.pend.dec = reg_wdata_in[lsr_pkg::POS_DEC +: 3];
        end
        lsr_pkg::OFS_ZERO: s_nxt.pend.zero = reg_wdata_in[15:0];
        lsr_pkg::OFS_SPAN: s_nxt.pend.span = reg_wdata_in[15:0];
        lsr_pkg::OFS_INTVL: s_nxt.pend.intvl = reg_wdata_in[7:0];
        default: ;
      endcase
    end
    // Operating state machine
    case (s_r.state)
      lsr_pkg::ST_MEAS: begin
        if (mode_p) begin
          s_nxt.state = lsr_pkg::ST_SETUP;
          s_nxt.item = lsr_pkg::ITEM_RETURN;
        end
      end
      lsr_pkg::ST_SETUP: begin
        if (up_p && !mode_key_in) begin
          s_nxt.item = (s_r.item == lsr_pkg::ITEM_SVC) ? lsr_pkg::ITEM_RETURN :
                       lsr_pkg::lsr_item_t'(s_r.item + 2'h1);
        end else if (down_p && !mode_key_in) begin
          s_nxt.item = (s_r.item == lsr_pkg::ITEM_RETURN) ? lsr_pkg::ITEM_SVC :
                       lsr_pkg::lsr_item_t'(s_r.item - 2'h1);
        end else if (acc_p) begin
          case (s_r.item)
            lsr_pkg::ITEM_RETURN: begin
              s_nxt.work = s_r.pend; // RULE_01
              s_nxt.state = lsr_pkg::ST_MEAS;
            end
            lsr_pkg::ITEM_TEST: begin
              s_nxt.state = lsr_pkg::ST_TEST;
              s_nxt.lcd = 8'h01;
              s_nxt.lcd_cnt = 8'h00;
            end
            default: s_nxt.state = lsr_pkg::ST_SVC;
          endcase
        end
      end
      lsr_pkg::ST_TEST: begin
        if (mode_p) begin
          s_nxt.state = lsr_pkg::ST_SETUP; // RULE_16
          s_nxt.lcd = 8'h00;
        end else if (tick) begin
          if (s_r.lcd_cnt + 8'h01 >= lsr_pkg::LCD_STEP_TICKS) begin
            s_nxt.lcd_cnt = 8'h00;
            s_nxt.lcd = {s_r.lcd[6:0], s_r.lcd[7]}; // RULE_16
          end else begin
            s_nxt.lcd_cnt = s_r.lcd_cnt + 8'h01;
          end
        end
      end
      lsr_pkg::ST_SVC: begin
        if (mode_p) begin
          s_nxt.state = lsr_pkg::ST_MEAS; // RULE_04
        end
      end
      default: s_nxt.state = lsr_pkg::ST_MEAS;
    endcase
    // Mode plus down held while the return item flashes cancels edits
    if (s_r.state == lsr_pkg::ST_SETUP && flashing && mode_key_in && down_key_in) begin
      if (s_r.hold_cnt > lsr_pkg::CANCEL_TICKS) begin
        s_nxt.pend = s_r.work; // RULE_02
      end else if (tick) begin
        s_nxt.hold_cnt = s_r.hold_cnt + 8'h01;
      end
    end else begin
      s_nxt.hold_cnt = 8'h00;
    end
    // Display value and decimals
    case (s_r.work.disp)
      lsr_pkg::DISP_SEG: s_nxt.disp_val = {12'h000, s_r.seg}; // RULE_13
      lsr_pkg::DISP_DIEL: s_nxt.disp_val = s_r.sample;
      lsr_pkg::DISP_FREQ: s_nxt.disp_val = s_r.freq;
      default: s_nxt.disp_val = 16'h0000;
    endcase
    s_nxt.disp_dec = (s_r.work.disp == lsr_pkg::DISP_DIEL) ? s_r.work.dec :
                     lsr_pkg::DEC_FLOAT; // RULE_14
    // Read data, standing the cycle after the strobe
    s_nxt.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        lsr_pkg::OFS_POINTS: s_nxt.rdata = {20'h00000, s_r.pend.on_pt, 4'h0, s_r.pend.off_pt};
        lsr_pkg::OFS_TIMERS: s_nxt.rdata = {16'h0000, s_r.pend.on_tm, s_r.pend.off_tm};
        lsr_pkg::OFS_CFG: begin
          s_nxt.rdata = {21'h000000, s_r.pend.dec, 2'h0, s_r.pend.disp, 3'h0, s_r.pend.pol};
        end
        lsr_pkg::OFS_ZERO: s_nxt.rdata = {16'h0000, s_r.pend.zero};
        lsr_pkg::OFS_SPAN: s_nxt.rdata = {16'h0000, s_r.pend.span};
        lsr_pkg::OFS_INTVL: s_nxt.rdata = {24'h000000, s_r.pend.intvl};
        lsr_pkg::OFS_STATUS: begin
          s_nxt.rdata = {19'h00000, flashing, s_r.state, 3'h0,
                         relay_energized_out, s_r.seg};
        end
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; power-up lands in measurement with committed defaults
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
      s_r.state <= lsr_pkg::ST_MEAS; // RULE_19
      s_r.item <= lsr_pkg::ITEM_RETURN;
      s_r.work <= SET_RST; // RULE_03 RULE_10 RULE_11
      s_r.pend <= SET_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Relay coil and contacts
  assign relay_energized_out = s_r.detect ^ s_r.work.pol; // RULE_09
  assign contact_no_closed_out = relay_energized_out; // RULE_18
  assign contact_nc_closed_out = !relay_energized_out;
  assign return_to_operation_indicator_out = flashing && s_r.blink;
  assign operation_indicator_out = (s_r.state == lsr_pkg::ST_MEAS); // RULE_19
  assign mode_state_out = s_r.state;
  assign disp_value_out = s_r.disp_val;
  assign disp_decimals_out = s_r.disp_dec;
  assign lcd_test_out = s_r.lcd;
  assign reg_rdata_out = s_r.rdata;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_commit;
    s_r.state == lsr_pkg::ST_SETUP && s_r.item == lsr_pkg::ITEM_RETURN &&
      acc_p && !up_p && !down_p;
  endsequence
  sequence s_svc_exit;
    s_r.state == lsr_pkg::ST_SVC && mode_p;
  endsequence

  a_commit_apply: assert property (s_commit |=> s_r.work.on_pt == $past(s_r.pend.on_pt) &&
    s_r.state == lsr_pkg::ST_MEAS) else $error("commit not applied"); // RULE_01
  a_cancel_hold: assert property (s_r.hold_cnt > lsr_pkg::CANCEL_TICKS && mode_key_in &&
    down_key_in && flashing && !reg_wr_in && !teach_zero_in && !teach_span_in
    |=> s_r.pend == s_r.work) else $error("cancel did not discard"); // RULE_02
  a_svc_return: assert property (s_svc_exit |=> s_r.state == lsr_pkg::ST_MEAS)
    else $error("service mode did not return"); // RULE_04
  a_points_order: assert property (points_ok(s_r.work.off_pt, s_r.work.on_pt) &&
    points_ok(s_r.pend.off_pt, s_r.pend.on_pt)) else $error("points out of order"); // RULE_05
  a_engage_delay: assert property ($rose(s_r.detect) |-> $past(on_exp))
    else $error("relay engaged without delay"); // RULE_08
  a_release_delay: assert property ($fell(s_r.detect) |-> $past(off_exp))
    else $error("relay released without delay"); // RULE_07
  a_contact_sense: assert property (contact_no_closed_out == (s_r.detect ^ s_r.work.pol) &&
    contact_nc_closed_out != contact_no_closed_out) else $error("contact sense wrong"); // RULE_18
  a_test_exit: assert property (s_r.state == lsr_pkg::ST_TEST && mode_p
    |=> s_r.state == lsr_pkg::ST_SETUP && s_r.lcd == 8'h00) else $error("test exit wrong"); // RULE_16
  a_sample_take: assert property (s_r.smp_stb |=> s_r.sample == $past(sample_in))
    else $error("sample not taken"); // RULE_12
endmodule // lsr_relay_logic
